// File: logic/pixel_decomp_params.svh
// Operation
// - 7-bit code 011sxxx: magnitude 16*field+92+7, sign bit 3.
// - 7-bit code 0011sxx: magnitude 32*field+220+15, sign bit 2.
// - all differential classes except 7-bit classes one and two and 6-bit class one saturate to 0..4095.
// - 7-bit PCM: base 64*low6; plus 31 if base > predicted, else 32.
// - 6-bit unpredicted pixel decodes to 64*code+32.
// - 6-bit mask 0x3C: 00,04,08,0C pick classes 1,3,5,7; no class 2.
// - 6-bit mask 0x38: 10,18 pick classes 4,6; else PCM; ordered tests.
// - 6-bit class one: sign bit 1, magnitude bit 0, no saturation.
// - 6-bit class three: sign bit 1, magnitude 4*bit0+2+1.
// - 6-bit class four: sign bit 2, magnitude 8*low2+10+3.
// - 6-bit class five: sign bit 1, magnitude 16*bit0+42+7.
// - 6-bit class six: sign bit 2, magnitude 32*low2+74+15.
// - 6-bit class seven: sign bit 1, magnitude 64*bit0+202+31.
// - 6-bit PCM: base 128*low5; plus 63 if base > predicted, else 64.
// - sign set subtracts magnitude from prediction, clear adds it.
// - 7-bit classes chosen in order by masks 0x78/0x70, else PCM.
`ifndef PIXEL_DECOMP_PARAMS_SVH
`define PIXEL_DECOMP_PARAMS_SVH

`define PIX_MAX        12'hFFF
`define UNPRED7_MUL    4'h5
`define UNPRED7_OFS    12'h010
`define UNPRED6_MUL    4'h6
`define UNPRED6_OFS    12'h020
`define PCM7_MASK      7'h3F
`define PCM7_SHIFT     4'h6
`define PCM7_OFS_GT    12'h01F
`define PCM7_OFS_LE    12'h020
`define PCM6_MASK      7'h1F
`define PCM6_SHIFT     4'h7
`define PCM6_OFS_GT    12'h03F
`define PCM6_OFS_LE    12'h040
`define MASK_78        7'h78
`define MASK_70        7'h70
`define MASK_3C        7'h3C
`define MASK_38        7'h38
`define CODE_00        7'h00
`define CODE_04        7'h04
`define CODE_08        7'h08
`define CODE_0C        7'h0C
`define CODE_10        7'h10
`define CODE_18        7'h18
`define CODE_20        7'h20
`define CODE_30        7'h30
`define D7_1_ADD       12'h000
`define D7_2_ADD       12'h004
`define D7_3_ADD       12'h00D
`define D7_4_ADD       12'h01F
`define D7_5_ADD       12'h063
`define D7_6_ADD       12'h0EB
`define D6_3_ADD       12'h003
`define D6_4_ADD       12'h00D
`define D6_5_ADD       12'h031
`define D6_6_ADD       12'h059
`define D6_7_ADD       12'h0E9

`endif

// File: logic/pixel_decomp_pkg.sv
package pixel_decomp_pkg;
  typedef enum logic [7:0] {
    CLS_NONE  = 8'h01,
    CLS_DIFF  = 8'h02,
    CLS_PCM   = 8'h04,
    CLS_PLAIN = 8'h08
  } class_kind_e;

  typedef struct packed {
    logic        valid;
    logic [11:0] pixel;
  } decode_state_s;
endpackage

// File: logic/pixel_decompression_decoder.sv
`timescale 1ns/1ps
`include "pixel_decomp_params.svh"
module pixel_decompression_decoder
  import pixel_decomp_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_valid,
  input  wire logic        i_scheme7,
  input  wire logic        i_predicted,
  input  wire logic [6:0]  i_code,
  input  wire logic [11:0] i_pred,
  output logic             o_valid,
  output logic      [11:0] o_pixel
);
  decode_state_s state_reg;
  decode_state_s state_next;
  class_kind_e   kind;
  logic [11:0]   mag;
  logic          sign;
  logic          sat;
  logic [11:0]   diff_pixel;
  logic [11:0]   base;
  logic [11:0]   plain;
  logic [6:0]    c;

  // ==========================================================
  // class selection and magnitude
  always_comb begin
    c     = i_code;
    kind  = CLS_PCM;
    mag   = 12'h000;
    sign  = 1'b0;
    sat   = 1'b1;
    base  = 12'h000;
    plain = 12'h000;
    if (i_scheme7) begin
      plain = 12'(c) << `UNPRED7_MUL;
      plain = plain + `UNPRED7_OFS;
      base  = 12'(c & `PCM7_MASK) << `PCM7_SHIFT;
      if ((c & `MASK_78) == `CODE_00) begin
        kind = CLS_DIFF;
        sign = c[2];
        mag  = 12'(c[1:0]) + `D7_1_ADD;
        sat  = 1'b0;
      end else if ((c & `MASK_78) == `CODE_08) begin
        kind = CLS_DIFF;
        sign = c[2];
        mag  = (12'(c[1:0]) << 1) + `D7_2_ADD;
        sat  = 1'b0;
      end else if ((c & `MASK_78) == `CODE_10) begin
        kind = CLS_DIFF;
        sign = c[2];
        mag  = (12'(c[1:0]) << 2) + `D7_3_ADD;
      end else if ((c & `MASK_70) == `CODE_20) begin
        kind = CLS_DIFF;
        sign = c[3];
        mag  = (12'(c[2:0]) << 3) + `D7_4_ADD;
      end else if ((c & `MASK_70) == `CODE_30) begin
        kind = CLS_DIFF;
        sign = c[3];
        mag  = (12'(c[2:0]) << 4) + `D7_5_ADD;
      end else if ((c & `MASK_78) == `CODE_18) begin
        kind = CLS_DIFF;
        sign = c[2];
        mag  = (12'(c[1:0]) << 5) + `D7_6_ADD;
      end
    end else begin
      plain = 12'(c[5:0]) << `UNPRED6_MUL;
      plain = plain + `UNPRED6_OFS;
      base  = 12'(c & `PCM6_MASK) << `PCM6_SHIFT;
      if ((c & `MASK_3C) == `CODE_00) begin
        kind = CLS_DIFF;
        sign = c[1];
        mag  = 12'(c[0]);
        sat  = 1'b0;
      end else if ((c & `MASK_3C) == `CODE_04) begin
        kind = CLS_DIFF;
        sign = c[1];
        mag  = (12'(c[0]) << 2) + `D6_3_ADD;
      end else if ((c & `MASK_38) == `CODE_10) begin
        kind = CLS_DIFF;
        sign = c[2];
        mag  = (12'(c[1:0]) << 3) + `D6_4_ADD;
      end else if ((c & `MASK_3C) == `CODE_08) begin
        kind = CLS_DIFF;
        sign = c[1];
        mag  = (12'(c[0]) << 4) + `D6_5_ADD;
      end else if ((c & `MASK_38) == `CODE_18) begin
        kind = CLS_DIFF;
        sign = c[2];
        mag  = (12'(c[1:0]) << 5) + `D6_6_ADD;
      end else if ((c & `MASK_3C) == `CODE_0C) begin
        kind = CLS_DIFF;
        sign = c[1];
        mag  = (12'(c[0]) << 6) + `D6_7_ADD;
      end
    end
    if (!i_predicted) begin
      kind = CLS_PLAIN;
    end
  end

  pixel_diff_apply u_apply (
    .i_pred     (i_pred),
    .i_mag      (mag),
    .i_sign     (sign),
    .i_saturate (sat),
    .o_pixel    (diff_pixel)
  );

  // ==========================================================
  // output select
  always_comb begin
    state_next       = state_reg;
    state_next.valid = i_valid;
    if (i_valid) begin
      case (kind)
        CLS_DIFF:  state_next.pixel = diff_pixel;
        CLS_PLAIN: state_next.pixel = plain;
        CLS_PCM: begin
          if (i_scheme7) begin
            state_next.pixel = base + ((base > i_pred) ?
                               `PCM7_OFS_GT : `PCM7_OFS_LE);
          end else begin
            state_next.pixel = base + ((base > i_pred) ?
                               `PCM6_OFS_GT : `PCM6_OFS_LE);
          end
        end
        default:   state_next.pixel = state_reg.pixel;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_valid = state_reg.valid;
  assign o_pixel = state_reg.pixel;
endmodule // pixel_decompression_decoder

// File: logic/pixel_diff_apply.sv
`timescale 1ns/1ps
`include "pixel_decomp_params.svh"
module pixel_diff_apply
  import pixel_decomp_pkg::*;
(
  input  wire logic [11:0] i_pred,
  input  wire logic [11:0] i_mag,
  input  wire logic        i_sign,
  input  wire logic        i_saturate,
  output logic      [11:0] o_pixel
);
  logic signed [13:0] wide;

  // ==========================================================
  // signed apply with clamp
  always_comb begin
    if (i_sign) begin
      wide = $signed({2'b00, i_pred}) - $signed({2'b00, i_mag});
    end else begin
      wide = $signed({2'b00, i_pred}) + $signed({2'b00, i_mag});
    end
    if (i_saturate && wide < 0) begin
      o_pixel = 12'h000;
    end else if (i_saturate && wide > $signed({2'b00, `PIX_MAX})) begin
      o_pixel = `PIX_MAX;
    end else begin
      o_pixel = wide[11:0];
    end
  end
endmodule // pixel_diff_apply

// File: tb/code_source.sv
`timescale 1ns/1ps
module code_source (
  input  logic        i_clock,
  output logic [21:0] o_word
);
  initial o_word = 22'h000000;
  // one code per falling edge; idle words carry junk
  task automatic drive(input logic [21:0] w);
    @(negedge i_clock);
    o_word <= w;
  endtask
endmodule // code_source

// File: tb/decoder_properties.sv
`timescale 1ns/1ps
module decoder_properties (
  input logic        i_clock,
  input logic        i_srst,
  input logic        i_valid,
  input logic        i_scheme7,
  input logic        i_predicted,
  input logic [6:0]  i_code,
  input logic [11:0] i_pred,
  input logic        o_valid,
  input logic [11:0] o_pixel
);
  // ==========
  // checks
  logic [2:0]  k_reg;
  logic [6:0]  c_reg;
  logic [11:0] p_reg;
  always_ff @(posedge i_clock) begin
    k_reg <= i_srst ? 3'h0 : {i_valid, i_scheme7, i_predicted};
    c_reg <= i_code;
    p_reg <= i_pred;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  a_out_latency: assert property (i_valid |=> o_valid)
    else $error("no pixel after code");
  a_unpred_six: assert property (k_reg == 3'h4 |->
    o_pixel == {c_reg[5:0], 6'h20}) else $error("bad 6-bit plain");
  a_unpred_seven: assert property (k_reg == 3'h6 |->
    o_pixel == {c_reg, 5'h10}) else $error("bad 7-bit plain");
  a_pcm_six: assert property (k_reg == 3'h5 && c_reg[5] |->
    o_pixel == ({c_reg[4:0], 7'h00} > p_reg ? {c_reg[4:0], 7'h3F}
    : {c_reg[4:0], 7'h40})) else $error("bad 6-bit pcm");
  a_pcm_seven: assert property (k_reg == 3'h7 && c_reg[6] |->
    o_pixel == ({c_reg[5:0], 6'h00} > p_reg ? {c_reg[5:0], 6'h1F}
    : {c_reg[5:0], 6'h20})) else $error("bad 7-bit pcm");
  a_class_one: assert property (k_reg == 3'h5 &&
    c_reg[5:2] == 4'h0 |->
    o_pixel == (c_reg[1] ? p_reg - c_reg[0] : p_reg + c_reg[0]))
    else $error("bad class one");
  a_sat_floor: assert property (k_reg == 3'h5 &&
    c_reg[5:1] == 5'h07 && p_reg < 12'h0E9 |-> o_pixel == 12'h000)
    else $error("no floor clamp");
  a_sat_ceil: assert property (k_reg == 3'h7 &&
    c_reg[6:2] == 5'h06 && p_reg > 12'hF14 |-> o_pixel == 12'hFFF)
    else $error("no ceiling clamp");
  a_no_spurious: assert property (!i_valid |=> !o_valid)
    else $error("pixel without code");
  a_pixel_hold: assert property (!k_reg[2] |-> $stable(o_pixel))
    else $error("pixel moved while idle");
  cover property (o_valid && o_pixel == 12'hFFF);
  cover property (o_valid && o_pixel == 12'h000);
  cover property (i_valid ##1 i_valid);
endmodule // decoder_properties
bind pixel_decompression_decoder decoder_properties chk (.*);

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import pixel_decomp_pkg::*;
  logic        i_clock = 0;
  logic        i_srst = 1;
  logic        i_valid, i_scheme7, i_predicted, o_valid;
  logic [6:0]  i_code;
  logic [11:0] i_pred, o_pixel, exp_px;
  logic [21:0] word;
  logic [11:0] q[$];
  int          n_errors = 0, tests_run = 0, cyc = 0;
  assign {i_valid, i_scheme7, i_predicted, i_code, i_pred} = word;
  always #2 i_clock = ~i_clock;
  code_source src (.i_clock(i_clock), .o_word(word));
  pixel_decompression_decoder uut (.i_clock(i_clock), .i_srst(i_srst),
    .i_valid(i_valid), .i_scheme7(i_scheme7), .i_predicted(i_predicted),
    .i_code(i_code), .i_pred(i_pred), .o_valid(o_valid), .o_pixel(o_pixel));
  // ==========
  // reference
  function automatic logic [11:0] ref_px(bit s7, bit p, logic [6:0] c,
                                         logic [11:0] pr);
    int m, b, e;
    bit sg, sat;
    e = pr;
    sat = 1;
    sg = s7 ? c[2] : c[1];
    if (!p) return s7 ? 12'(32 * c + 16) : 12'(64 * c[5:0] + 32);
    if (s7) begin
      b = 64 * c[5:0];
      if (c[6]) return 12'(b > e ? b + 31 : b + 32);
      else if (c[5:3] == 0) begin m = c[1:0]; sat = 0; end
      else if (c[5:3] == 1) begin m = 2 * c[1:0] + 4; sat = 0; end
      else if (c[5:3] == 2) m = 4 * c[1:0] + 13;
      else if (c[5:4] == 2) begin m = 8 * c[2:0] + 31; sg = c[3]; end
      else if (c[5:4] == 3) begin m = 16 * c[2:0] + 99; sg = c[3]; end
      else m = 32 * c[1:0] + 235;
    end else begin
      b = 128 * c[4:0];
      if (c[5]) return 12'(b > e ? b + 63 : b + 64);
      else if (c[5:2] == 0) begin m = c[0]; sat = 0; end
      else if (c[5:2] == 1) m = 4 * c[0] + 3;
      else if (c[5:3] == 2) begin m = 8 * c[1:0] + 13; sg = c[2]; end
      else if (c[5:2] == 2) m = 16 * c[0] + 49;
      else if (c[5:3] == 3) begin m = 32 * c[1:0] + 89; sg = c[2]; end
      else m = 64 * c[0] + 233;
    end
    b = sg ? e - m : e + m;
    b = !sat ? b : b < 0 ? 0 : b > 4095 ? 4095 : b;
    return 12'(b);
  endfunction
  task automatic send(bit v, bit s7, bit p, logic [6:0] c, logic [11:0] e);
    if (v) q.push_back(ref_px(s7, p, c, e));
    src.drive(v ? {v, s7, p, c, e} : {1'b0, 21'($urandom)});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic flush(string name);
    repeat (3) send(0, 0, 0, 7'h00, 12'h000);
    tests_run++;
    if (q.size() != 0) begin
      n_errors++;
      $display("CHECK FAILED pending exp 0 got %0d", q.size());
    end
    $display("test %s done", name);
  endtask
  // ==========
  // scoreboard and timeout
  always @(negedge i_clock) if (!i_srst && o_valid === 1'b1) begin
    exp_px = q.size() > 0 ? q.pop_front() : 12'hXXX;
    tests_run++;
    if (o_pixel !== exp_px) begin
      n_errors++;
      $display("CHECK FAILED o_pixel exp %h got %h", exp_px, o_pixel);
    end
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    void'($urandom(51));
    repeat (8) @(posedge i_clock);
    @(negedge i_clock) i_srst = 0;
    for (int k = 0; k < 1536; k++)
      send(1, k[0], k[1], k[8:2], k > 1023 ? 12'($urandom) :
           k > 511 ? 12'hFFF : 12'h000);
    flush("sweep");
    repeat (800) send(1'($urandom), 1'($urandom), 1'($urandom),
                      7'($urandom), 12'($urandom));
    flush("random");
    close_out();
  end
endmodule // tb
